// [rtl/hbf_pkg.sv]
// Package for the half-band rate-change I/O block: widths, formats, mode codes.
// Assumes a single 50 MHz clock; shared by the datapath top module.
package hbf_pkg;
    localparam int IN_W       = 12;
    localparam int OUT_W      = 16;
    localparam int ACC_W      = 20;
    localparam int OUT_SHIFT  = 4;
    localparam int RND_W      = 3;
    localparam int TAP_N      = 7;
    localparam int CLK_HZ     = 50000000;
    localparam logic [ACC_W-1:0] ACC_MAX = 20'h07fff;
    localparam logic [ACC_W-1:0] ACC_MIN = 20'hf8000;
    localparam logic [OUT_W-1:0] SIGN_FLIP = 16'h8000;
    localparam logic [OUT_W-1:0] ZERO_OUT  = 16'h0000;
    localparam logic [IN_W-1:0]  ZERO_IN   = 12'h000;
    localparam logic [IN_W-1:0]  IN_SIGN   = 12'h800;

    typedef enum logic [1:0] {
        HBF_MODE_EQUAL,
        HBF_MODE_INTERP,
        HBF_MODE_DECIM,
        HBF_MODE_BYPASS
    } hbf_mode_type;
endpackage

// [rtl/hbf_core.sv]
// Half-band rate-change datapath: input capture, zero stuffing, phase strobe,
// fixed short half-band filter, rounding, saturation, output formatting.
// Assumes pins are synchronous to clk except arst_n and output_enable_n, which are async.
`timescale 1ns/1ps
`default_nettype none
module hbf_core
    import hbf_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Mode and format controls
    input  wire logic              interpolate_select,
    input  wire logic              decimate_select,
    input  wire logic              bypass_select,
    input  wire logic              output_format_select,
    input  wire logic              input_unsigned,
    input  wire logic              output_unsigned,
    input  wire logic [RND_W-1:0]  rounding_position,
    input  wire logic              output_enable_n,
    // Phase alignment strobe
    input  wire logic              phase_sync,
    // Data
    input  wire logic [IN_W-1:0]   sample_in_bus,
    output logic      [OUT_W-1:0]  sample_out_bus,
    output logic      [OUT_W-1:0]  sample_out_oe
);
    typedef struct packed {
        logic [IN_W-1:0]           in_word;
        logic                      sync_d;
        logic                      phase;
        logic [TAP_N-1:0][IN_W:0]  taps;
        logic [OUT_W-1:0]          out_word;
        logic [OUT_W-1:0]          drive_mask;
    } hbf_state_type;

    hbf_state_type st_reg;
    hbf_state_type st_next;
    hbf_mode_type  mode;

    // Mask of active bits: everything at and below rounding point is off
    function automatic logic [OUT_W-1:0] active_mask(input logic [RND_W-1:0] r);
        logic [OUT_W-1:0] m;
        m = ~ZERO_OUT;
        if (r != 3'h0) begin
            m = ~ZERO_OUT << (r + 4'h1);
        end
        return m;
    endfunction

    always_comb begin
        if (bypass_select) begin
            mode = HBF_MODE_BYPASS;
        end else if (interpolate_select && !decimate_select) begin
            mode = HBF_MODE_INTERP;
        end else if (decimate_select && !interpolate_select) begin
            mode = HBF_MODE_DECIM;
        end else begin
            mode = HBF_MODE_EQUAL;
        end
    end

    logic signed [ACC_W-1:0] acc;
    logic signed [ACC_W-1:0] rounded;
    logic        [OUT_W-1:0] sat;
    logic        [IN_W:0]    in_ext;
    logic        [IN_W-1:0]  in_conv;
    logic                    take_sample;
    logic                    load_out;
    logic                    phase_now;
    logic        [OUT_W-1:0] half_lsb;

    always_comb begin
        st_next = st_reg;
        // Input registered every edge, unsigned converted to signed
        st_next.in_word = sample_in_bus;
        st_next.sync_d  = phase_sync;
        // Strobe high then low marks edge 1 as the sample phase
        if (st_reg.sync_d && !phase_sync) begin
            phase_now = 1'b1;
        end else begin
            phase_now = ~st_reg.phase;
        end
        // Strobe has no effect outside the rate-change modes
        if (mode != HBF_MODE_INTERP && mode != HBF_MODE_DECIM) begin
            phase_now = 1'b1;
        end
        st_next.phase = phase_now;
        in_conv = input_unsigned ? (st_reg.in_word ^ IN_SIGN) : st_reg.in_word;
        in_ext  = {in_conv[IN_W-1], in_conv};
        // Held word was captured one edge ago, so use that edge's phase
        take_sample = (mode != HBF_MODE_INTERP) || st_reg.phase;
        st_next.taps = {st_reg.taps[TAP_N-2:0], take_sample ? in_ext : {1'b0, ZERO_IN}};
        // Short half-band kernel (-1, 0, 9, 16, 9, 0, -1)/32, unity at Nyquist-free DC
        if (mode == HBF_MODE_BYPASS) begin
            acc = ACC_W'(signed'(st_reg.taps[3])) <<< OUT_SHIFT;
        end else begin
            acc = ACC_W'(signed'(st_reg.taps[2])) * ACC_W'(9)
                + ACC_W'(signed'(st_reg.taps[4])) * ACC_W'(9)
                + (ACC_W'(signed'(st_reg.taps[3])) <<< 4)
                - ACC_W'(signed'(st_reg.taps[0])) - ACC_W'(signed'(st_reg.taps[6]));
            // Taps sum to 32; zero stuffing already halves it, else halve here
            if (mode != HBF_MODE_INTERP) begin
                acc = acc >>> 1;
            end
        end
        // Unity weight puts input bit 0 at output bit 4
        // Half-LSB rounding at chosen position
        half_lsb = (rounding_position == 3'h0) ? ZERO_OUT : (16'h0001 << rounding_position);
        rounded = acc + ACC_W'(half_lsb);
        // Clamp instead of wrapping
        if (rounded > signed'(ACC_MAX)) begin
            sat = 16'h7fff;
        end else if (rounded < signed'(ACC_MIN)) begin
            sat = 16'h8000;
        end else begin
            sat = rounded[OUT_W-1:0];
        end
        sat = sat & active_mask(rounding_position);
        // Format select: two's complement, unsigned, or inverted offset
        if (!output_format_select) begin
            sat = output_unsigned ? sat ^ SIGN_FLIP : ~(sat ^ SIGN_FLIP);
        end
        // Decimation loads output only on even phase edges
        load_out = (mode != HBF_MODE_DECIM) || !phase_now;
        if (load_out) begin
            st_next.out_word = sat;
        end
        st_next.drive_mask = active_mask(rounding_position);
    end

    // Every register runs on each rising edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign sample_out_bus = st_reg.out_word;
    // Enable passes straight through, no clock wait
    assign sample_out_oe = output_enable_n ? ZERO_OUT : st_reg.drive_mask;
endmodule
`default_nettype wire

// [testbench/hbf_core_checker.sv]
// Port checker for hbf_core.
// Assumes binding to every hbf_core.
`timescale 1ns/1ps
`default_nettype none
module hbf_core_checker
    import hbf_pkg::*;
(
    input wire logic clk, arst_n, interpolate_select, decimate_select, bypass_select,
    input wire logic [RND_W-1:0] rounding_position,
    input wire logic output_enable_n, phase_sync,
    input wire logic [OUT_W-1:0] sample_out_bus, sample_out_oe
);
    wire logic dm = decimate_select & ~interpolate_select & ~bypass_select;
    wire logic [2:0] rp = rounding_position;
    wire logic [15:0] so = sample_out_bus;
    wire logic [15:0] oe = sample_out_oe;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    chk_oe_off: assert property (output_enable_n |-> oe == 16'h0000)
        else $error("oe high");
    chk_oe_full: assert property (!output_enable_n && rp == 3'h0
        && $past(rp) == 3'h0 && $past(arst_n) |-> oe == 16'hffff) else $error("oe not full");
    chk_oe_mask: assert property (!output_enable_n && rp == 3'h4
        && $past(rp) == 3'h4 && $past(arst_n) |-> oe == 16'hffe0) else $error("oe mask");
    chk_oe_lsb: assert property (rp != 3'h0 && $past(rp) != 3'h0 |-> !oe[0])
        else $error("lsb driven");
    chk_round_zero: assert property (rp == 3'h4 && $past(rp, 2) == 3'h4 |-> so[4:0] == 5'h00)
        else $error("low bits set");
    chk_decim_hold: assert property ($past(dm) && dm && $changed(so) |=> $stable(so))
        else $error("back to back change");
    chk_sync_hold: assert property (dm && phase_sync ##1 dm && !phase_sync |=> $stable(so))
        else $error("update on hold edge");
    chk_reset_zero: assert property ($rose(arst_n) |-> so == 16'h0000)
        else $error("not cleared");
    cover property (dm && phase_sync);
    cover property (interpolate_select && !decimate_select && phase_sync);
    cover property ($rose(output_enable_n));
endmodule
bind hbf_core hbf_core_checker chk (.*);
`default_nettype wire

// [testbench/hbf_host_model.sv]
// Host source: phase strobe and alternating words.
// Assumes align is a one-cycle request.
`timescale 1ns/1ps
`default_nettype none
module hbf_host_model (
    input  wire logic        clk, align,
    input  wire logic [11:0] odd_val, even_val,
    output var  logic        phase_sync = 1'b0,
    output var  logic [11:0] sample_in_bus = 12'h000
);
    logic odd_next = 1'b0;
    always @(posedge clk) begin
        phase_sync <= align;
        sample_in_bus <= (odd_next && !align) ? odd_val : even_val;
        odd_next <= align | ~odd_next;
    end
endmodule
`default_nettype wire

// [testbench/tb_hbf_core.sv]
// Bench for hbf_core.
// Assumes the host model and bound checker.
`timescale 1ns/1ps
`default_nettype none
module tb_hbf_core;
    logic clk = 1'b0, arst_n = 1'b0, isel = 1'b0, dsel = 1'b0, bsel = 1'b1, fmt = 1'b1;
    logic ou = 1'b0, oe_n = 1'b0, align = 1'b0, ps;
    logic [2:0] rnd = 3'h0;
    logic [11:0] ov = 12'h5a3, ev = 12'h5a3, si;
    logic [15:0] so, soe;
    int failures = 0, num_checks = 0;
    always #10 clk = ~clk;
    hbf_host_model host (.clk(clk), .align(align), .odd_val(ov), .even_val(ev),
        .phase_sync(ps), .sample_in_bus(si));
    hbf_core uut (.clk(clk), .arst_n(arst_n), .interpolate_select(isel),
        .decimate_select(dsel), .bypass_select(bsel), .output_format_select(fmt),
        .input_unsigned(1'b0), .output_unsigned(ou), .rounding_position(rnd),
        .output_enable_n(oe_n), .phase_sync(ps), .sample_in_bus(si),
        .sample_out_bus(so), .sample_out_oe(soe));
    task automatic wrap_up;
        if (failures == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] e, input logic [15:0] g);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("mismatch %0t %h %h", $time, e, g);
        end
    endtask
    // Bounded wait for the pipeline to reach a value
    task automatic settle(input logic [15:0] e);
        for (int n = 0; n < 80 && so !== e; n++)
            @(negedge clk);
        cmp(e, so);
    endtask
    // Mode bits: interp, decim, bypass, format, unsigned; one strobe pulse
    task automatic mode(input logic [4:0] m, input logic [11:0] o, input logic [11:0] v);
        @(posedge clk);
        {isel, dsel, bsel, fmt, ou} <= m;
        ov <= o;
        ev <= v;
        align <= 1'b1;
        @(posedge clk);
        align <= 1'b0;
    endtask
    initial begin
        #200000;
        failures++;
        wrap_up();
    end
    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        mode(5'b00110, 12'h5a3, 12'h5a3);
        settle(16'h5a30);
        mode(5'b00101, 12'h5a3, 12'h5a3);
        settle(16'hda30);
        mode(5'b00100, 12'h5a3, 12'h5a3);
        settle(16'h25cf);
        @(posedge clk) oe_n <= 1'b1;
        #1 cmp(16'h0000, soe);
        @(posedge clk);
        oe_n <= 1'b0;
        rnd <= 3'h4;
        mode(5'b00110, 12'h5a3, 12'h5a3);
        settle(16'h5a40);
        cmp(16'hffe0, soe);
        mode(5'b11010, 12'h7ff, 12'h7ff);
        settle(16'h7fe0);
        @(posedge clk) rnd <= 3'h0;
        mode(5'b11010, 12'h800, 12'h800);
        settle(16'h8000);
        mode(5'b10010, 12'h100, 12'h7ff);
        settle(16'h1000);
        mode(5'b01010, 12'h100, 12'h100);
        settle(16'h1000);
        wrap_up();
    end
endmodule
`default_nettype wire
